// ===== rtl/i2c_slave_pkg.sv
/*
  constants, register map, field positions and state codes of the
  two-wire slave port core.
  assumes a single 40 MHz clock and an 8-bit register model.
*/
package i2c_slave_pkg;
  // word offsets on the register bus
  localparam logic [2:0] OFS_BUF = 3'h0;
  localparam logic [2:0] OFS_ADDR = 3'h1;
  localparam logic [2:0] OFS_STAT = 3'h2;
  localparam logic [2:0] OFS_CTL1 = 3'h3;
  localparam logic [2:0] OFS_CTL2 = 3'h4;
  localparam logic [2:0] OFS_IRQ = 3'h5;
  localparam logic [2:0] OFS_IMSK = 3'h6;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_MSK = 8'hff;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [6:0] RST_BRG = 7'h00;
  // port_control_one fields
  localparam int C1_WCOL = 7;
  localparam int C1_OVF = 6;
  localparam int C1_EN = 5;
  localparam int C1_CKP = 4;
  // slave_control_two fields
  localparam int C2_GENERAL_CALL_ENABLE = 7;
  localparam int C2_MSK_HI = 5;
  localparam int C2_MSK_LO = 2;
  localparam int C2_MSK1 = 1;
  localparam int C2_SEN = 0;
  // port_status_register: bits 7:6 writable
  localparam int ST_WR_LO = 6;
  // interrupt status / mask bits
  localparam int IRQ_W = 5;
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_OVF = 3;
  localparam int IRQ_GCALL = 4;
  localparam logic [IRQ_W-1:0] RST_IRQ = 5'h00;
  // port_mode_field codes
  localparam logic [3:0] MODE_SL7 = 4'h6;
  localparam logic [3:0] MODE_SL10 = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_MSK7 = 4'h9;
  localparam logic [3:0] MODE_SL7_SP = 4'he;
  localparam logic [3:0] MODE_SL10_SP = 4'hf;
  // addresses and bit counts
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR2 = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_WAIT = 3'b101
  } slave_state_t;
endpackage : i2c_slave_pkg

// ===== rtl/i2c_line_watch.sv
/*
  bus line watcher: registered clock and data levels, clock edges,
  start and stop conditions.
  assumes pin inputs already synchronous to clock.
*/
`timescale 1ns/100ps
module i2c_line_watch (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_q,
  output logic sda_q,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  logic scl_d_reg;
  logic sda_d_reg;

  // idle bus is high, so history starts high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      scl_d_reg <= scl_q;
      sda_d_reg <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_d_reg;
  assign scl_fall = ~scl_q & scl_d_reg;
  // data moving while clock stays high
  assign start_det = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
  assign stop_det = scl_q & scl_d_reg & ~sda_d_reg & sda_q;
endmodule : i2c_line_watch

// ===== rtl/i2c_slave_port_core.sv
/*
  two-wire serial port core, mainly addressed slave, with an
  avalon-mm register slave and one level interrupt.
  assumes open-drain pads outside; both lines pulled low only through the enables.
*/
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
module i2c_slave_port_core
  import i2c_slave_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  logic ack_reg;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [7:0] wd;
  logic [7:0] rd_mux;
  logic [7:0] own_address_or_reload;
  logic [7:0] address_mask_register;
  logic [7:0] slave_control_two;
  logic [7:0] transfer_buffer;
  logic [7:0] rx_tx_shift_reg;
  logic wcol_reg;
  logic ovf_reg;
  logic en_reg;
  logic clock_release_bit;
  logic [3:0] port_mode_field;
  logic [1:0] stat_hi_reg;
  logic da_reg;
  logic stop_reg;
  logic start_reg;
  logic rw_reg;
  logic ua_reg;
  logic bf_reg;
  logic [IRQ_W-1:0] irq_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic [IRQ_W-1:0] irq_set;
  slave_state_t state_reg;
  slave_state_t state_next;
  logic [3:0] cnt_reg;
  logic sda_low_reg;
  logic hold_reg;
  logic matched10_reg;
  logic [6:0] brg_cnt_reg;
  logic mclk_low_reg;
  logic scl_q;
  logic sda_q;
  logic line_rise;
  logic line_fall;
  logic start_det;
  logic stop_det;
  logic ten;
  logic general_call_enable;
  logic clock_hold_enable;
  logic [3:0] address_mask_select;
  logic [7:0] mask_vec;
  logic [7:0] diff;
  logic hit7;
  logic hit_full;
  logic gcall;
  logic addr_hit;
  logic rx_state;
  logic byte_end;
  logic take;
  logic ovf_set;
  logic tx_end;
  logic tx_start;
  logic tx_busy;
  logic buf_wr;
  logic buf_load;
  logic buf_rd;
  logic ckp_clr;

  i2c_line_watch u_watch (
    .clock(clock),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_q(scl_q),
    .sda_q(sda_q),
    .scl_rise(line_rise),
    .scl_fall(line_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // bus slave: one wait cycle, answer on the second edge
  assign req = read | write;
  assign waitrequest = req & ~ack_reg;
  assign wr_go = write & ack_reg & byteenable[0];
  assign rd_go = read & ack_reg;
  assign wd = writedata[7:0];
  assign buf_wr = wr_go & (address == OFS_BUF);
  assign buf_rd = rd_go & (address == OFS_BUF);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    unique case (address)
      OFS_BUF: rd_mux = transfer_buffer;
      OFS_ADDR: rd_mux = (port_mode_field == MODE_MSK7) ?
        address_mask_register : own_address_or_reload;
      OFS_STAT: rd_mux = {stat_hi_reg, da_reg, stop_reg, start_reg,
        rw_reg, ua_reg, bf_reg};
      OFS_CTL1: rd_mux = {wcol_reg, ovf_reg, en_reg, clock_release_bit,
        port_mode_field};
      OFS_CTL2: rd_mux = slave_control_two;
      OFS_IRQ: rd_mux = {3'h0, irq_reg};
      OFS_IMSK: rd_mux = {3'h0, imask_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // captured on the first edge; stands through the answer edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      readdata <= {24'h00_0000, rd_mux};
    end
  end

  // own address and mask share one offset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      own_address_or_reload <= RST_BYTE;
      address_mask_register <= RST_MSK;
    end else if (wr_go && address == OFS_ADDR) begin
      if (port_mode_field == MODE_MSK7) begin
        address_mask_register <= wd;
      end else begin
        own_address_or_reload <= wd;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slave_control_two <= RST_BYTE;
      stat_hi_reg <= 2'b00;
      imask_reg <= RST_IRQ;
    end else if (wr_go) begin
      if (address == OFS_CTL2) begin
        slave_control_two <= wd;
      end
      if (address == OFS_STAT) begin
        stat_hi_reg <= wd[7:ST_WR_LO];
      end
      if (address == OFS_IMSK) begin
        imask_reg <= wd[IRQ_W-1:0];
      end
    end
  end

  assign general_call_enable = slave_control_two[C2_GENERAL_CALL_ENABLE];
  assign clock_hold_enable = slave_control_two[C2_SEN];
  assign address_mask_select = slave_control_two[C2_MSK_HI:C2_MSK_LO];

  // error flags: hardware set wins over a software clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wcol_reg <= 1'b0;
      ovf_reg <= 1'b0;
      en_reg <= 1'b0;
      clock_release_bit <= 1'b0;
      port_mode_field <= RST_MODE;
    end else begin
      if (wr_go && address == OFS_CTL1) begin
        wcol_reg <= wd[C1_WCOL] | (buf_wr & tx_busy);
        ovf_reg <= wd[C1_OVF] | ovf_set;
        en_reg <= wd[C1_EN];
        clock_release_bit <= wd[C1_CKP] & ~ckp_clr;
        port_mode_field <= wd[3:0];
      end else begin
        wcol_reg <= wcol_reg | (buf_wr & tx_busy);
        ovf_reg <= ovf_reg | ovf_set;
        clock_release_bit <= clock_release_bit & ~ckp_clr;
      end
    end
  end

  // address match
  assign ten = (port_mode_field == MODE_SL10) |
    (port_mode_field == MODE_SL10_SP);
  always_comb begin
    if (port_mode_field == MODE_MSK7) begin
      mask_vec = {address_mask_register[7:1], 1'b0};
    end else begin
      mask_vec = {2'b00, address_mask_select,
        slave_control_two[C2_MSK1],
        slave_control_two[C2_MSK1] & ten};
    end
  end
  assign diff = (rx_tx_shift_reg ^ own_address_or_reload) & ~mask_vec;
  assign hit7 = (diff[7:1] == 7'h00);
  assign hit_full = (diff == 8'h00);
  assign gcall = general_call_enable &
    (rx_tx_shift_reg == GCALL_ADDR) & (state_reg == ST_ADDR);

  always_comb begin
    unique case (state_reg)
      ST_ADDR: addr_hit = gcall | (hit7 & (!ten ||
        rx_tx_shift_reg[7:3] == TEN_PREFIX));
      ST_ADDR2: addr_hit = hit_full;
      ST_RX: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign rx_state = (state_reg == ST_ADDR) | (state_reg == ST_ADDR2) |
    (state_reg == ST_RX);
  assign byte_end = en_reg & line_fall & rx_state & (cnt_reg == BIT_LAST);
  // a full buffer refuses the byte and flags overrun
  assign take = byte_end & addr_hit & ~bf_reg;
  assign ovf_set = byte_end & addr_hit & bf_reg;
  assign tx_end = en_reg & line_rise & (state_reg == ST_TX) &
    (cnt_reg == BIT_ACK);
  // without stretching, late software may miss the low phase
  assign tx_start = en_reg & (state_reg == ST_TX) & (cnt_reg == 4'h0) &
    ~scl_q & bf_reg;
  assign tx_busy = (state_reg == ST_TX) & (cnt_reg != 4'h0);
  assign buf_load = buf_wr & ~tx_busy;
  // hold only after the ack clock, so the master can clock the ack
  assign ckp_clr = clock_hold_enable & ((line_fall & (cnt_reg == BIT_ACK) &
    sda_low_reg) | (tx_end & ~sda_q));

  always_comb begin
    state_next = ST_WAIT;
    unique case (state_reg)
      ST_ADDR: begin
        if (!addr_hit) begin
          state_next = ST_WAIT;
        end else if (gcall) begin
          state_next = ST_RX;
        end else if (ten) begin
          state_next = (rx_tx_shift_reg[0] && matched10_reg) ?
            ST_TX : ST_ADDR2;
        end else begin
          state_next = rx_tx_shift_reg[0] ? ST_TX : ST_RX;
        end
      end
      ST_ADDR2: state_next = addr_hit ? ST_RX : ST_WAIT;
      ST_RX: state_next = ST_RX;
      default: state_next = ST_WAIT;
    endcase
  end

  // byte engine
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      rx_tx_shift_reg <= RST_BYTE;
      sda_low_reg <= 1'b0;
    end else if (!en_reg || stop_det) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end else begin
      if (buf_load) begin
        rx_tx_shift_reg <= wd;
      end
      if (rx_state && line_rise && cnt_reg < BIT_LAST) begin
        rx_tx_shift_reg <= {rx_tx_shift_reg[6:0], sda_q};
        cnt_reg <= cnt_reg + 4'h1;
      end
      if (byte_end) begin
        sda_low_reg <= take;
        cnt_reg <= BIT_ACK;
        state_reg <= take ? state_next : ST_WAIT;
      end
      if (line_fall && cnt_reg == BIT_ACK) begin
        sda_low_reg <= 1'b0;
        cnt_reg <= 4'h0;
      end
      if (tx_start) begin
        sda_low_reg <= ~rx_tx_shift_reg[7];
        rx_tx_shift_reg <= {rx_tx_shift_reg[6:0], 1'b0};
        cnt_reg <= 4'h1;
      end
      if (state_reg == ST_TX && line_fall) begin
        if (cnt_reg != 4'h0 && cnt_reg < BIT_LAST) begin
          sda_low_reg <= ~rx_tx_shift_reg[7];
          rx_tx_shift_reg <= {rx_tx_shift_reg[6:0], 1'b0};
          cnt_reg <= cnt_reg + 4'h1;
        end else if (cnt_reg == BIT_LAST) begin
          sda_low_reg <= 1'b0;
          cnt_reg <= BIT_ACK;
        end
      end
      if (tx_end && sda_q) begin
        state_reg <= ST_WAIT;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      transfer_buffer <= RST_BYTE;
    end else if (take) begin
      transfer_buffer <= rx_tx_shift_reg;
    end else if (buf_load) begin
      transfer_buffer <= wd;
    end
  end

  // status flags; setting events win over clears
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      da_reg <= 1'b0;
      stop_reg <= 1'b0;
      start_reg <= 1'b0;
      rw_reg <= 1'b0;
      ua_reg <= 1'b0;
      bf_reg <= 1'b0;
      matched10_reg <= 1'b0;
    end else if (!en_reg) begin
      stop_reg <= 1'b0;
      start_reg <= 1'b0;
      bf_reg <= 1'b0;
      matched10_reg <= 1'b0;
    end else begin
      if (start_det) begin
        start_reg <= 1'b1;
        stop_reg <= 1'b0;
      end
      if (stop_det) begin
        stop_reg <= 1'b1;
        start_reg <= 1'b0;
        matched10_reg <= 1'b0;
      end
      if (take) begin
        da_reg <= (state_reg == ST_RX);
      end
      if (take && state_reg == ST_ADDR) begin
        rw_reg <= rx_tx_shift_reg[0];
      end
      if (take && state_reg == ST_ADDR2) begin
        matched10_reg <= 1'b1;
      end
      if (wr_go && address == OFS_ADDR) begin
        ua_reg <= 1'b0;
      end
      if (take && ten && !gcall && state_reg != ST_RX &&
          !(state_reg == ST_ADDR && state_next == ST_TX)) begin
        ua_reg <= 1'b1;
      end
      if (buf_rd || tx_end) begin
        bf_reg <= 1'b0;
      end
      if (take || (buf_load && state_reg == ST_TX)) begin
        bf_reg <= 1'b1;
      end
    end
  end

  // sticky events; a read clears only the bits it returned
  assign irq_set[IRQ_BYTE] = take | tx_end;
  assign irq_set[IRQ_START] = en_reg & start_det;
  assign irq_set[IRQ_STOP] = en_reg & stop_det;
  assign irq_set[IRQ_OVF] = ovf_set;
  assign irq_set[IRQ_GCALL] = take & gcall;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= RST_IRQ;
    end else if (rd_go && address == OFS_IRQ) begin
      irq_reg <= (irq_reg & ~readdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_reg <= irq_reg | irq_set;
    end
  end

  assign irq = |(irq_reg & imask_reg);

  // clock hold only joins a low the line already has
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hold_reg <= 1'b0;
    end else if (clock_release_bit || !en_reg) begin
      hold_reg <= 1'b0;
    end else if (!scl_q) begin
      hold_reg <= 1'b1;
    end
  end

  // master baud generator only; no master byte sequencing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      brg_cnt_reg <= RST_BRG;
      mclk_low_reg <= 1'b0;
    end else if (!en_reg || port_mode_field != MODE_MASTER) begin
      brg_cnt_reg <= RST_BRG;
      mclk_low_reg <= 1'b0;
    end else if (brg_cnt_reg == RST_BRG) begin
      brg_cnt_reg <= own_address_or_reload[6:0];
      mclk_low_reg <= ~mclk_low_reg;
    end else begin
      brg_cnt_reg <= brg_cnt_reg - 7'h01;
    end
  end

  // open drain: output level fixed low, enable low drives
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~(hold_reg | mclk_low_reg);
  assign sda_oe_n = ~sda_low_reg;
endmodule : i2c_slave_port_core

// ===== dv/i2c_slave_port_core_sva.sv
/*
  checker for the port core: bus handshake, irq, pin drive.
  assumes one clock domain; bound to every core instance.
*/
`timescale 1ns/100ps
module i2c_port_chk
  import i2c_slave_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  logic [3:0] mode_q;
  // shadow of the mode field: master mode pulls the clock by itself
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= 4'h0;
    end else if (write && !waitrequest && address == OFS_CTL1
                 && byteenable[0]) begin
      mode_q <= writedata[3:0];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence bus_req;
    (read || write) && waitrequest;
  endsequence
  sequence bus_ans;
    (read || write) && !waitrequest;
  endsequence
  chk_wait_one: assert property (bus_req |=> bus_ans)
    else $error("waitrequest held beyond one cycle");
  chk_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without request");
  chk_unmapped_zero: assert property (
    bus_ans ##0 (read && address == 3'h7) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_upper: assert property (bus_ans |-> readdata[31:8] == 24'h0)
    else $error("readdata upper bits set");
  chk_irq_fall: assert property ($fell(irq) |-> $past(read || write))
    else $error("irq dropped without register access");
  chk_pins_od: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  chk_sda_scl_low: assert property (
    $changed(sda_oe_n) |-> !$past(scl_in))
    else $error("data drive changed with clock high");
  chk_scl_after_low: assert property (
    $fell(scl_oe_n) && mode_q != MODE_MASTER
      |-> !$past(scl_in) || !$past(scl_in, 2))
    else $error("clock pulled while line high");
endmodule : i2c_port_chk

bind i2c_slave_port_core i2c_port_chk chk (
  .clock(clock), .rstn(rstn), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n)
);

// ===== dv/i2c_master_model.sv
/*
  behavioural bus master: start, stop, byte write and read.
  assumes wired-and lines with pull-ups resolved by the bench.
*/
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  localparam int HALF = 8;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic hw(input int k);
    repeat (k) @(posedge clock);
  endtask : hw
  // a stretching slave may hold the line; bounded wait
  task automatic rel_scl;
    int k;
    k = 0;
    scl_pull <= 1'b0;
    do begin
      @(posedge clock);
      k++;
    end while (scl !== 1'b1 && k < 5000);
  endtask : rel_scl
  // also serves as repeated start
  task automatic start_c;
    sda_pull <= 1'b0;
    hw(HALF);
    rel_scl;
    hw(HALF);
    sda_pull <= 1'b1;
    hw(HALF);
    scl_pull <= 1'b1;
    hw(HALF);
  endtask : start_c
  task automatic stop_c;
    sda_pull <= 1'b1;
    hw(HALF);
    rel_scl;
    hw(HALF);
    sda_pull <= 1'b0;
    hw(HALF);
  endtask : stop_c
  // data stays put while the clock is high; hold after the fall
  task automatic bit_out(input logic b);
    sda_pull <= ~b;
    hw(HALF);
    rel_scl;
    hw(HALF);
    scl_pull <= 1'b1;
    hw(2);
  endtask : bit_out
  task automatic bit_in(output logic b);
    sda_pull <= 1'b0;
    hw(HALF);
    rel_scl;
    hw(HALF / 2);
    b = sda;
    hw(HALF / 2);
    scl_pull <= 1'b1;
    hw(2);
  endtask : bit_in
  task automatic wr_byte(input logic [7:0] dv, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(dv[i]);
    bit_in(a);
    ack = ~a;
  endtask : wr_byte
  task automatic rd_byte(output logic [7:0] dv, input logic ack);
    for (int i = 7; i >= 0; i--) bit_in(dv[i]);
    bit_out(~ack);
  endtask : rd_byte
endmodule : i2c_master_model

// ===== dv/i2c_slave_port_core_tb_top.sv
/*
  self-checking bench: register access, receive, match, transmit
  with stretching, baud generator.
  assumes the core, its checker and the master model compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module i2c_slave_port_core_tb_top
  import i2c_slave_pkg::*;
;
  logic clock, rstn, read, write, ack;
  logic [2:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  logic waitrequest, irq, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic [7:0] q, d;
  wire scl_line, sda_line, scl_pull, sda_pull;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  // control two, address byte, expected irq status (bit 0 is the ack)
  logic [23:0] cases [6] = '{24'h00_54_06, 24'h08_5a_07,
    24'h02_50_07, 24'h04_5a_06, 24'h80_00_17, 24'h00_00_06};
  assign scl_line = (scl_oe_n | scl_out) & ~scl_pull;
  assign sda_line = (sda_oe_n | sda_out) & ~sda_pull;
  always #12.5 clock = ~clock;
  i2c_slave_port_core dut (
    .clock(clock), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n)
  );
  i2c_master_model m (
    .clock(clock), .scl(scl_line), .sda(sda_line),
    .scl_pull(scl_pull), .sda_pull(sda_pull)
  );
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [7:0] dv, output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clock);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= {24'h0, dv};
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) err_total++;
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [7:0] dv);
    bus(1'b1, a, dv, q);
  endtask : wr
  task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                     input string nm);
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask : rdc
  // irq comes from registers: let the access edge land first
  task automatic irq_is(input logic e);
    @(posedge clock);
    `CHK("irq", e, irq)
  endtask : irq_is
  task automatic gap(output int k);
    logic p;
    p = scl_oe_n;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (scl_oe_n === p && k < 300);
  endtask : gap
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    complete_run;
  end
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 3'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rdc(OFS_CTL2, 8'h00, "ctl2 reset");
    rdc(OFS_ADDR, 8'h00, "own reset");
    wr(3'h7, 8'h5a);
    rdc(3'h7, 8'h00, "unmapped");
    wr(OFS_STAT, 8'hff);
    rdc(OFS_STAT, 8'hc0, "status");
    wr(OFS_CTL2, 8'ha5);
    rdc(OFS_CTL2, 8'ha5, "ctl2");
    wr(OFS_CTL1, 8'h19);
    rdc(OFS_CTL1, 8'h19, "ctl1");
    rdc(OFS_ADDR, 8'hff, "mask reset");
    wr(OFS_ADDR, 8'h0e);
    wr(OFS_CTL1, 8'h16);
    rdc(OFS_ADDR, 8'h00, "own kept");
    wr(OFS_ADDR, 8'h52);
    wr(OFS_IMSK, 8'h1f);
    wr(OFS_CTL2, 8'h00);
    wr(OFS_CTL1, 8'h36);
    m.start_c;
    m.wr_byte(8'h52, ack);
    `CHK("addr ack", 1'b1, ack)
    `CHK("irq", 1'b1, irq)
    rdc(OFS_IRQ, 8'h03, "start irq");
    rdc(OFS_BUF, 8'h52, "addr byte");
    m.wr_byte(8'ha7, ack);
    rdc(OFS_BUF, 8'ha7, "rx byte");
    m.stop_c;
    wr(OFS_IMSK, 8'h00);
    irq_is(1'b0);
    wr(OFS_IMSK, 8'h1f);
    irq_is(1'b1);
    rdc(OFS_IRQ, 8'h05, "stop irq");
    irq_is(1'b0);
    foreach (cases[i]) begin
      wr(OFS_CTL2, cases[i][23:16]);
      m.start_c;
      m.wr_byte(cases[i][15:8], ack);
      m.stop_c;
      bus(1'b0, OFS_BUF, 8'h00, q);
      bus(1'b0, OFS_IRQ, 8'h00, q);
      `CHK("match irq", cases[i][7:0], q)
      `CHK("match ack", cases[i][0], ack)
    end
    wr(OFS_CTL2, 8'h01);
    m.start_c;
    m.wr_byte(8'h53, ack);
    `CHK("read ack", 1'b1, ack)
    fork
      m.rd_byte(d, 1'b0);
      begin
        bus(1'b0, OFS_BUF, 8'h00, q);
        bus(1'b0, OFS_IRQ, 8'h00, q);
        `CHK("clock held", 1'b0, scl_oe_n)
        wr(OFS_BUF, 8'hc3);
        wr(OFS_CTL1, 8'h36);
      end
    join
    `CHK("tx byte", 8'hc3, d)
    m.stop_c;
    wr(OFS_CTL2, 8'h00);
    wr(OFS_ADDR, 8'h83);
    wr(OFS_CTL1, 8'h38);
    gap(n);
    gap(n);
    `CHK("baud gap", 4, n)
    wr(OFS_CTL1, 8'h00);
    complete_run;
  end
endmodule : i2c_slave_port_core_tb_top
